// >>> rtl/pplm_top.v
// phy power and link manager: automatic power saving and inline-power search
// assumes one 100 MHz clock, ahb-lite master, media pins asynchronous
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "pplm_regs.vh"
module pplm_top #(
   parameter [16:0] TICK_CYC = `PPLM_TICK_CYC
) (
   // clock and reset
   input wire clk_i,
   input wire rst_b_i,
   // ahb-lite slave
   input wire hsel_i,
   input wire [7:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire hready_i,
   input wire [31:0] hwdata_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   // media side pins
   input wire energy_i,
   input wire flp_loop_i,
   input wire unmanaged_strap_i,
   // phy core status, same clock
   input wire link_up_i,
   // media side controls
   output reg flp_detect_tx_o,
   output reg wake_burst_o,
   output reg wake_pair_b_o,
   output reg core_power_down_o,
   output reg aneg_run_o,
   // open-drain management interrupt
   output reg mgmt_interrupt_n_o,
   output reg mgmt_interrupt_n_oe_o
);

localparam PW_LOW = 2'd0;
localparam PW_WAKE = 2'd1;
localparam PW_NORM = 2'd2;
localparam DS_OFF = 2'd0;
localparam DS_SEARCH = 2'd1;
localparam DS_AN = 2'd2;

function [12:0] pick_ms;
   input [1:0] sel;
   input [12:0] d0;
   input [12:0] d1;
   input [12:0] d2;
   input [12:0] d3;
   begin
      case (sel)
         2'd0: pick_ms = d0;
         2'd1: pick_ms = d1;
         2'd2: pick_ms = d2;
         default: pick_ms = d3;
      endcase
   end
endfunction

// pin synchronisers: three stages, a change counts once stages two and three agree
wire [2:0] pin_raw;
wire [2:0] pin_s2;
wire [2:0] pin_s3;
reg [2:0] pin_val_r;
assign pin_raw = {unmanaged_strap_i, flp_loop_i, energy_i};
genvar gi;
generate
   for (gi = 0; gi < 3; gi = gi + 1)
   begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      always @(posedge clk_i)
      begin
         if (!rst_b_i)
         begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
         end
         else
         begin
            s1_r <= pin_raw[gi];
            s2_r <= s1_r;
            s3_r <= s2_r;
         end
      end
      assign pin_s2[gi] = s2_r;
      assign pin_s3[gi] = s3_r;
   end
endgenerate

always @(posedge clk_i)
begin
   if (!rst_b_i)
      pin_val_r <= 3'b000;
   else
      pin_val_r <= (pin_s2 & pin_s3) | (pin_val_r & (pin_s2 | pin_s3));
end

wire energy_w = pin_val_r[0];
wire loop_w = pin_val_r[1];
wire strap_w = pin_val_r[2];

// registers and bus state
reg [11:0] ctrl_r;
reg [1:0] det_stat_r;
reg det_int_r;
reg [1:0] pw_state_r;
reg [1:0] ds_state_r;
reg [7:0] addr_r;
reg wr_pend_r;
reg rd_pend_r;
reg [2:0] strap_cnt_r;
reg strap_done_r;

wire aneg_en = ctrl_r[`PPLM_CTRL_ANEG];
wire pdwn = ctrl_r[`PPLM_CTRL_PDWN];
wire det_en = ctrl_r[`PPLM_CTRL_DET];
wire save_en = ctrl_r[`PPLM_CTRL_SAVE];
wire pin_en = ctrl_r[`PPLM_CTRL_PINEN];
wire [1:0] slp_sel = ctrl_r[`PPLM_CTRL_SLP_LO+1:`PPLM_CTRL_SLP_LO];
wire [1:0] wak_sel = ctrl_r[`PPLM_CTRL_WAK_LO+1:`PPLM_CTRL_WAK_LO];
wire [1:0] lst_sel = ctrl_r[`PPLM_CTRL_LST_LO+1:`PPLM_CTRL_LST_LO];

wire bus_take = hsel_i & htrans_i[1] & hready_i;
wire wr_ctrl = wr_pend_r & (addr_r == `PPLM_ADDR_CTRL);
wire rd_stat = rd_pend_r & (addr_r == `PPLM_ADDR_STAT);
wire det_found;
wire det_giveup;

reg [31:0] rd_mux;
always @*
begin
   rd_mux = 32'h0000_0000;
   case (addr_r)
      `PPLM_ADDR_CTRL: rd_mux[11:0] = ctrl_r;
      `PPLM_ADDR_STAT:
      begin
         rd_mux[`PPLM_ST_DET_LO+1:`PPLM_ST_DET_LO] = det_stat_r;
         rd_mux[`PPLM_ST_LINK] = link_up_i;
         rd_mux[`PPLM_ST_PWR_LO+1:`PPLM_ST_PWR_LO] = pw_state_r;
         rd_mux[`PPLM_ST_INT] = det_int_r;
      end
      default: rd_mux = 32'h0000_0000;
   endcase
end

// writes are zero-wait; reads take one wait state so hrdata is registered
always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      addr_r <= 8'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0000_0000;
   end
   else
   begin
      wr_pend_r <= 1'b0;
      if (rd_pend_r)
      begin
         hrdata_o <= rd_mux;
         hreadyout_o <= 1'b1;
         rd_pend_r <= 1'b0;
      end
      else if (bus_take)
      begin
         addr_r <= {haddr_i[7:2], 2'b00};
         wr_pend_r <= hwrite_i;
         rd_pend_r <= ~hwrite_i;
         hreadyout_o <= hwrite_i;
      end
   end
end

// control register; the strap is caught a few cycles after reset release
always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      ctrl_r <= `PPLM_CTRL_RST;
      strap_cnt_r <= 3'd0;
      strap_done_r <= 1'b0;
   end
   else
   begin
      if (!strap_done_r)
      begin
         strap_cnt_r <= strap_cnt_r + 3'd1;
         if (strap_cnt_r == `PPLM_STRAP_WAIT)
         begin
            strap_done_r <= 1'b1;
            if (strap_w)
               ctrl_r[`PPLM_CTRL_SAVE] <= 1'b1;
         end
      end
      if (wr_ctrl)
         ctrl_r <= hwdata_i[11:0];
      else if (det_giveup)
         ctrl_r[`PPLM_CTRL_DET] <= 1'b0;
   end
end

// millisecond tick from the system clock
reg [16:0] div_r;
reg tick_r;
always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      div_r <= 17'h0_0000;
      tick_r <= 1'b0;
   end
   else
   begin
      tick_r <= (div_r == TICK_CYC - 17'h0_0001);
      if (div_r == TICK_CYC - 17'h0_0001)
         div_r <= 17'h0_0000;
      else
         div_r <= div_r + 17'h0_0001;
   end
end

// free-running lfsr spreads the sleep period so two sleepers drift apart
reg [15:0] lfsr_r;
always @(posedge clk_i)
begin
   if (!rst_b_i)
      lfsr_r <= `PPLM_LFSR_SEED;
   else
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
end
wire [7:0] rnd_raw = lfsr_r[7:0];
wire [7:0] rnd_ofs = (rnd_raw > `PPLM_RND_SPAN) ? rnd_raw - `PPLM_RND_FOLD :
                     rnd_raw;
wire [12:0] slp_base = pick_ms(slp_sel, `PPLM_SLP_MS0, `PPLM_SLP_MS1,
                               `PPLM_SLP_MS2, `PPLM_SLP_MS3);
wire [12:0] slp_ms = slp_base - `PPLM_RND_NEG_MS + {5'd0, rnd_ofs};
wire [12:0] wak_ms = pick_ms(wak_sel, `PPLM_WAK_MS0, `PPLM_WAK_MS1,
                             `PPLM_WAK_MS2, `PPLM_WAK_MS3);
wire [12:0] lst_ms = pick_ms(lst_sel, `PPLM_LST_MS0, `PPLM_LST_MS1,
                             `PPLM_LST_MS2, `PPLM_LST_MS3);

// power-saving state machine
reg [1:0] pw_nxt;
reg [12:0] pw_cnt_r;
reg [12:0] pw_lim_r;
reg stay_norm_r;
reg [4:0] slot_r;
reg [1:0] bursts_r;
wire pw_expire = tick_r & (pw_cnt_r >= pw_lim_r);

always @*
begin
   pw_nxt = pw_state_r;
   case (pw_state_r)
      PW_LOW:
      begin
         // hold low until the strap has had its say on the enable bit
         if ((!save_en && strap_done_r) || energy_w)
            pw_nxt = PW_NORM;
         else if (pw_expire)
            pw_nxt = PW_WAKE;
      end
      PW_WAKE:
      begin
         if (!save_en || energy_w)
            pw_nxt = PW_NORM;
         else if (pw_expire)
            pw_nxt = PW_LOW;
      end
      PW_NORM:
      begin
         if (save_en && aneg_en && !stay_norm_r && !link_up_i && pw_expire)
            pw_nxt = PW_LOW;
      end
      default: pw_nxt = PW_LOW;
   endcase
end

always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      pw_state_r <= PW_LOW;
      pw_cnt_r <= 13'h0_000;
      pw_lim_r <= `PPLM_SLP_MS1;
      stay_norm_r <= 1'b0;
      slot_r <= 5'h00;
      bursts_r <= 2'd0;
   end
   else
   begin
      pw_state_r <= pw_nxt;
      if (pw_nxt != pw_state_r)
      begin
         pw_cnt_r <= 13'h0_000;
         slot_r <= 5'h00;
         bursts_r <= 2'd0;
         if (pw_nxt == PW_LOW)
            pw_lim_r <= slp_ms;
         else if (pw_nxt == PW_WAKE)
            pw_lim_r <= wak_ms;
         else
            pw_lim_r <= lst_ms;
      end
      else if (pw_state_r == PW_NORM && link_up_i)
         pw_cnt_r <= 13'h0_000;
      else if (tick_r)
      begin
         pw_cnt_r <= pw_cnt_r + 13'h0_001;
         if (pw_state_r == PW_WAKE)
         begin
            slot_r <= slot_r + 5'h01;
            if (slot_r == `PPLM_BURST_SLOT_MS - 5'h01 &&
                bursts_r != `PPLM_BURST_MAX)
               bursts_r <= bursts_r + 2'd1;
         end
      end
      if (pw_state_r == PW_NORM && pw_nxt == PW_NORM)
      begin
         if (pw_lim_r != lst_ms)
            pw_lim_r <= lst_ms;
      end
      // forced speed or autoneg dropped in normal state pins it there
      if (!save_en)
         stay_norm_r <= 1'b0;
      else if (pw_state_r == PW_NORM && !aneg_en)
         stay_norm_r <= 1'b1;
   end
end

// inline-power detection machine
reg [12:0] det_cnt_r;
reg link_seen_r;
assign det_found = (ds_state_r == DS_SEARCH) & loop_w;
assign det_giveup = (ds_state_r == DS_SEARCH) & ~loop_w & tick_r &
                    (det_cnt_r >= `PPLM_DET_LIMIT_MS);

always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      ds_state_r <= DS_OFF;
      det_stat_r <= `PPLM_DET_SEARCH;
      det_cnt_r <= 13'h0_000;
      link_seen_r <= 1'b0;
   end
   else
   begin
      case (ds_state_r)
         DS_OFF:
         begin
            link_seen_r <= 1'b0;
            det_cnt_r <= 13'h0_000;
            if (det_en && aneg_en)
            begin
               ds_state_r <= DS_SEARCH;
               det_stat_r <= `PPLM_DET_SEARCH;
            end
         end
         DS_SEARCH:
         begin
            if (tick_r)
               det_cnt_r <= det_cnt_r + 13'h0_001;
            if (det_found)
            begin
               det_stat_r <= `PPLM_DET_FOUND;
               ds_state_r <= DS_AN;
            end
            else if (det_giveup)
            begin
               det_stat_r <= `PPLM_DET_NONE;
               ds_state_r <= DS_AN;
            end
            else if (!det_en && !aneg_en)
               ds_state_r <= DS_OFF;
         end
         DS_AN:
         begin
            if (link_up_i)
               link_seen_r <= 1'b1;
            else if (link_seen_r)
            begin
               // link lost: search again
               link_seen_r <= 1'b0;
               det_cnt_r <= 13'h0_000;
               det_stat_r <= `PPLM_DET_SEARCH;
               ds_state_r <= DS_SEARCH;
            end
            if (!aneg_en)
               ds_state_r <= DS_OFF;
         end
         default: ds_state_r <= DS_OFF;
      endcase
   end
end

// detection event bit: a new event beats a clearing read
always @(posedge clk_i)
begin
   if (!rst_b_i)
      det_int_r <= 1'b0;
   else if (det_found)
      det_int_r <= 1'b1;
   else if (rd_stat)
      det_int_r <= 1'b0;
end

// registered outputs; management stays clocked in every power state
always @(posedge clk_i)
begin
   if (!rst_b_i)
   begin
      flp_detect_tx_o <= 1'b0;
      wake_burst_o <= 1'b0;
      wake_pair_b_o <= 1'b0;
      core_power_down_o <= 1'b1;
      aneg_run_o <= 1'b0;
      mgmt_interrupt_n_o <= 1'b0;
      mgmt_interrupt_n_oe_o <= 1'b0;
   end
   else
   begin
      flp_detect_tx_o <= (ds_state_r == DS_SEARCH) & ~pdwn;
      wake_burst_o <= (pw_state_r == PW_WAKE) & (slot_r == 5'h00) &
                      (bursts_r != `PPLM_BURST_MAX);
      wake_pair_b_o <= bursts_r[0];
      core_power_down_o <= pdwn | (pw_state_r != PW_NORM);
      aneg_run_o <= aneg_en & ~pdwn & (pw_state_r == PW_NORM) &
                    (ds_state_r != DS_SEARCH);
      mgmt_interrupt_n_o <= 1'b0;
      mgmt_interrupt_n_oe_o <= det_int_r & pin_en;
   end
end

endmodule // pplm_top

// >>> rtl/pplm_regs.vh
// constants for the phy power and link manager
// assumes a 100 MHz clock and a word-wide ahb-lite register slave
//
// Function
// - while searching, send special pulses and report detection status 00
// - looped-back pulses seen set the detection status to 01
// - loopback sets the detection event bit; reading it clears it
// - no loopback within the detection limit sets the status to 10
// - on status 10 detection stops itself and auto-negotiation runs
// - link status bit reads 1 once a link is established
// - link failure stops auto-negotiation and restarts inline-power search
// - a plain power-down bit exists apart from automatic power saving
// - writing the power-saving enable to 1 enables it at any time
// - without energy, cycle low-power and wake-up at a set rate, 2 s default
// - signal energy on the media moves the machine to normal state
// - with autoneg on, link loss returns to low power after the time-out
// - after reset the machine starts in the low-power state
// - forced speed from low power: cycle, then stay normal after link drop
// - autoneg disabled in normal state keeps it normal on link loss
// - major blocks off in low-power and wake-up; management stays alive
// - sleep period from a two-bit field, randomly offset by -80 to +60 ms
// - wake-up sends up to three bursts on alternate pairs, then sleeps
// - two bits select the link-status time-out; expiry enters low power
// - an unmanaged strap makes power saving enabled by default
// - an event drives the open-drain interrupt low only when pin-enabled
`ifndef PPLM_REGS_VH
`define PPLM_REGS_VH
// one millisecond counted in 100 MHz cycles
`define PPLM_TICK_CYC 17'h1_86A0
`define PPLM_ADDR_CTRL 8'h00
`define PPLM_ADDR_STAT 8'h04
`define PPLM_CTRL_ANEG 0
`define PPLM_CTRL_PDWN 1
`define PPLM_CTRL_DET 2
`define PPLM_CTRL_SAVE 3
`define PPLM_CTRL_PINEN 4
`define PPLM_CTRL_SLP_LO 5
`define PPLM_CTRL_WAK_LO 7
`define PPLM_CTRL_LST_LO 9
`define PPLM_CTRL_RST 12'h0_021
`define PPLM_ST_DET_LO 0
`define PPLM_ST_LINK 2
`define PPLM_ST_PWR_LO 3
`define PPLM_ST_INT 5
`define PPLM_DET_SEARCH 2'h0
`define PPLM_DET_FOUND 2'h1
`define PPLM_DET_NONE 2'h2
`define PPLM_SLP_MS0 13'h0_3E8
`define PPLM_SLP_MS1 13'h0_7D0
`define PPLM_SLP_MS2 13'h0_BB8
`define PPLM_SLP_MS3 13'h0_FA0
`define PPLM_WAK_MS0 13'h0_064
`define PPLM_WAK_MS1 13'h0_0C8
`define PPLM_WAK_MS2 13'h0_190
`define PPLM_WAK_MS3 13'h0_320
`define PPLM_LST_MS0 13'h0_3E8
`define PPLM_LST_MS1 13'h0_7D0
`define PPLM_LST_MS2 13'h0_BB8
`define PPLM_LST_MS3 13'h0_FA0
`define PPLM_DET_LIMIT_MS 13'h0_1F4
`define PPLM_RND_NEG_MS 13'h0_050
`define PPLM_RND_SPAN 8'h8C
`define PPLM_RND_FOLD 8'h80
`define PPLM_BURST_SLOT_MS 5'h10
`define PPLM_BURST_MAX 2'h3
`define PPLM_LFSR_SEED 16'hACE1
`define PPLM_STRAP_WAIT 3'h4
`endif

// >>> tb/pplm_link_partner.sv
// link partner model: media energy, pulse loopback and link status
// assumes the bench says when a cable is plugged or a device wants power
`timescale 1ns/10ps
module pplm_link_partner (
   // clock
   input wire clk_i,
   // bench controls
   input wire plugged_i,
   input wire wants_power_i,
   input wire slow_i,
   // phy side
   input wire flp_detect_tx_i,
   input wire aneg_run_i,
   output reg energy_o,
   output reg flp_loop_o,
   output reg link_up_o
);
   reg [5:0] dly_r = 6'h00;
   initial
   begin
      energy_o = 1'b0;
      flp_loop_o = 1'b0;
      link_up_o = 1'b0;
   end
   always @(posedge clk_i)
   begin
      energy_o <= plugged_i;
      // an unpowered device only echoes pulses while they are sent
      if (flp_detect_tx_i && wants_power_i && !plugged_i)
         dly_r <= dly_r + {5'h00, dly_r != 6'h3F};
      else
         dly_r <= 6'h00;
      flp_loop_o <= dly_r > (slow_i ? 6'h28 : 6'h02);
      link_up_o <= plugged_i && aneg_run_i;
   end
endmodule // pplm_link_partner

// >>> tb/pplm_top_assertions.sv
// port assertions for the phy power and link manager
// assumes bind into pplm_top; read data lags the address by one wait
`timescale 1ns/10ps
module pplm_top_assertions #(
   parameter [16:0] TICK_CYC = 17'd10
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire hsel_i,
   input wire [7:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire wake_burst_o,
   input wire wake_pair_b_o,
   input wire core_power_down_o,
   input wire mgmt_interrupt_n_o,
   input wire mgmt_interrupt_n_oe_o
);
   reg [16:0] burst_len_r;
   wire take = hsel_i && htrans_i[1] && hready_i;
   always @(posedge clk_i)
   begin
      if (!rst_b_i || !wake_burst_o)
         burst_len_r <= 17'd0;
      else
         burst_len_r <= burst_len_r + 17'd1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_resp_okay: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
   a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write data phase stalled");
   a_read_wait: assert property
      (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait not exactly one cycle");
   a_rdata_hold: assert property ($changed(hrdata_o) |-> !$past(hreadyout_o))
      else $error("read data moved outside a read");
   a_int_level: assert property (mgmt_interrupt_n_o == 1'b0)
      else $error("interrupt pin value not low");
   a_int_clear: assert property
      (take && !hwrite_i && haddr_i[7:2] == 6'h01 && mgmt_interrupt_n_oe_o
       |-> ##3 !mgmt_interrupt_n_oe_o)
      else $error("interrupt kept after status read");
   a_burst_asleep: assert property (wake_burst_o |-> core_power_down_o)
      else $error("wake burst with core powered");
   a_burst_len: assert property ($rose(wake_burst_o) |-> wake_burst_o[*8])
      else $error("wake burst too short");
   a_burst_max: assert property (burst_len_r <= TICK_CYC)
      else $error("wake burst too long");
   a_pair_steady: assert property
      (wake_burst_o && $past(wake_burst_o) |-> $stable(wake_pair_b_o))
      else $error("pair changed inside a burst");
endmodule // pplm_top_assertions
bind pplm_top pplm_top_assertions #(.TICK_CYC(TICK_CYC)) pplm_top_assertions_i (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .wake_burst_o(wake_burst_o), .wake_pair_b_o(wake_pair_b_o),
   .core_power_down_o(core_power_down_o),
   .mgmt_interrupt_n_o(mgmt_interrupt_n_o),
   .mgmt_interrupt_n_oe_o(mgmt_interrupt_n_oe_o));

// >>> tb/tb.sv
// self-checking bench for the phy power and link manager
// assumes pplm_regs.vh on the include path; one ms is ten cycles here
`timescale 1ns/10ps
`include "pplm_regs.vh"
`define CHK(g, e) \
   begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
   logic clk_i = 0, rst_b_i = 0, hsel_i = 0, hwrite_i = 0, strap = 1;
   logic [7:0] haddr_i = 0;
   logic [1:0] htrans_i = 0;
   logic [31:0] hwdata_i = 0, hrdata_o, d;
   logic hreadyout_o, hresp_o, energy, loopb, link, plugged = 0, wants = 0;
   logic flp_tx, burst, pair_b, core_pd, aneg_run, int_n, int_oe;
   logic burst_q = 0, last_pair;
   int bad_count = 0, samples_checked = 0, bursts = 0, pair_bad = 0, i;
   always #5 clk_i = ~clk_i;
   pplm_top #(.TICK_CYC(17'd10)) pplm_top_i (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .energy_i(energy),
      .flp_loop_i(loopb), .unmanaged_strap_i(strap), .link_up_i(link),
      .flp_detect_tx_o(flp_tx), .wake_burst_o(burst),
      .wake_pair_b_o(pair_b), .core_power_down_o(core_pd),
      .aneg_run_o(aneg_run), .mgmt_interrupt_n_o(int_n),
      .mgmt_interrupt_n_oe_o(int_oe));
   pplm_link_partner pplm_link_partner_i (.clk_i(clk_i),
      .plugged_i(plugged), .wants_power_i(wants), .slow_i(1'b1),
      .flp_detect_tx_i(flp_tx), .aneg_run_i(aneg_run), .energy_o(energy),
      .flp_loop_o(loopb), .link_up_o(link));
   // bursts must alternate pairs, so remember the pair of the last one
   always @(posedge clk_i)
   begin
      burst_q <= burst;
      if (burst === 1'b1 && burst_q === 1'b0)
      begin
         bursts++;
         if (bursts > 1 && pair_b === last_pair)
            pair_bad++;
         last_pair <= pair_b;
      end
   end
   task automatic finish_test;
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 50);
      if (hreadyout_o !== 1'b1)
      begin
         bad_count++;
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= w;
      wait_rdy();
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      wait_rdy();
      d = hrdata_o;
   endtask
   // status reads until a field matches; too many reads end the run
   task automatic poll(input logic [31:0] m, input logic [31:0] v,
      input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
         if ((d & m) === v)
            return;
      end
      bad_count++;
      finish_test();
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_CTRL, 32'h0);
      `CHK(d[11:0], `PPLM_CTRL_RST | 12'h0_008)
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h0)
      `CHK(core_pd, 1'b1)
      bus(1'b0, 8'h10, 32'h0);
      `CHK(d, 32'h0000_0000)
      bus(1'b1, `PPLM_ADDR_CTRL, 32'h0000_0009);
      repeat (9000) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h0)
      poll(32'h18, 32'h08, 8000);
      `CHK(core_pd, 1'b1)
      poll(32'h18, 32'h00, 1000);
      `CHK(bursts, int'(`PPLM_BURST_MAX))
      `CHK(pair_bad, 0)
      // second sleep is 1000 ms less 80 plus 0..140: still low at 900 ms
      repeat (9000) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h0)
      poll(32'h18, 32'h08, 700);
      poll(32'h18, 32'h00, 1000);
      plugged <= 1'b1;
      poll(32'h18, 32'h10, 50);
      `CHK(core_pd, 1'b0)
      bus(1'b1, `PPLM_ADDR_CTRL, 32'h0000_000B);
      repeat (2) @(posedge clk_i);
      `CHK(core_pd, 1'b1)
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h2)
      plugged <= 1'b0;
      wants <= 1'b1;
      bus(1'b1, `PPLM_ADDR_CTRL, 32'h0000_001D);
      repeat (2) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[1:0], `PPLM_DET_SEARCH)
      `CHK(flp_tx, 1'b1)
      for (i = 0; i < 200 && int_oe !== 1'b1; i++)
         @(posedge clk_i);
      `CHK(int_oe, 1'b1)
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[5], 1'b1)
      `CHK(d[1:0], `PPLM_DET_FOUND)
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[5], 1'b0)
      `CHK(int_oe, 1'b0)
      wants <= 1'b0;
      plugged <= 1'b1;
      poll(32'h04, 32'h04, 50);
      `CHK(aneg_run, 1'b1)
      plugged <= 1'b0;
      repeat (30) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[1:0], `PPLM_DET_SEARCH)
      `CHK(flp_tx, 1'b1)
      repeat (6000) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[1:0], `PPLM_DET_NONE)
      `CHK(d[4:3], 2'h2)
      bus(1'b0, `PPLM_ADDR_CTRL, 32'h0);
      `CHK(d[2], 1'b0)
      `CHK(aneg_run, 1'b1)
      poll(32'h18, 32'h00, 3000);
      plugged <= 1'b1;
      poll(32'h18, 32'h10, 50);
      bus(1'b1, `PPLM_ADDR_CTRL, 32'h0000_0008);
      plugged <= 1'b0;
      repeat (12000) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h2)
      // reset again with the strap low: power saving stays off
      strap <= 1'b0;
      rst_b_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      bus(1'b0, `PPLM_ADDR_CTRL, 32'h0);
      `CHK(d[11:0], `PPLM_CTRL_RST)
      bus(1'b0, `PPLM_ADDR_STAT, 32'h0);
      `CHK(d[4:3], 2'h2)
      finish_test();
   end
endmodule // tb
